// ### common/sdvs_pkg.sv
// Shared constants and types of the signed divide sequencer.
// Assumes one 40 MHz clock and a host core that owns the register file.
package sdvs_pkg;

   // Data word width of the host datapath
   localparam int WORD_W = 16;

   // Pass counter width and entry value, octal 17 so that 16 passes run
   localparam int          CNT_W    = 4;
   localparam logic [3:0]  CNT_INIT = 4'hF;
   localparam logic [3:0]  CNT_STEP = 4'h1;
   localparam logic [3:0]  CNT_LAST = 4'h0;

   // Most negative sixteen-bit value, octal 100000
   localparam logic [15:0] MOST_NEG  = 16'h8000;
   localparam logic [15:0] WORD_ZERO = 16'h0000;

   // Condition code group, N Z V C from high bit to low bit
   typedef struct packed {
      logic n;   // Negative
      logic z;   // Zero
      logic v;   // Overflow
      logic c;   // Carry
   } sdvs_cc_s;

   // Reset value and divide-by-zero value of the codes
   localparam sdvs_cc_s CC_RESET    = 4'h0;
   localparam sdvs_cc_s CC_ZERO_DIV = 4'h7;

   // Sequencer states
   typedef enum logic [2:0] {
      S_IDLE  = 3'h0,   // Waiting for start
      S_ZTEST = 3'h1,   // Divisor zero test, dividend sign
      S_NEG   = 3'h2,   // Make dividend positive
      S_FIRST = 3'h3,   // First pass and overflow test
      S_LOOP  = 3'h4,   // Remaining passes
      S_CORR  = 3'h5,   // Remainder correction
      S_FIX   = 3'h6,   // Sign fix of remainder and quotient
      S_DONE  = 3'h7    // Hand codes and results to host
   } sdvs_state_e;

endpackage

// ### logic/sdvs_negate16.sv
// Sixteen-bit negation slice: inverts a word and adds a carry in.
// Assumes chaining of two slices for a 32-bit two's complement.
`timescale 1ns/10ps
module sdvs_negate16 (
   // Operand and carry in
   input  wire logic [15:0] a,
   input  wire logic        cin,
   // Result and carry out
   output logic [15:0]      y,
   output logic             cout
);

   // Ones complement plus carry, with the carry out kept
   always_comb begin
      {cout, y} = {1'b0, ~a} + {16'h0000, cin};
   end

endmodule

// ### logic/sdvs_divider.sv
// Signed 32 by 16 divide sequencer with non-restoring passes.
// Assumes the host supplies operands, writes results back, owns the status word.
`timescale 1ns/10ps
module sdvs_divider (
   // Clock and reset
   input  wire logic                       ref_clk,
   input  wire logic                       srst,
   // Host request and operands
   input  wire logic                       start,
   input  wire logic [sdvs_pkg::WORD_W-1:0] even_source_register,
   input  wire logic [sdvs_pkg::WORD_W-1:0] odd_companion_register,
   input  wire logic [sdvs_pkg::WORD_W-1:0] destination_operand_register,
   // Results toward the register file
   output logic [sdvs_pkg::WORD_W-1:0]      quotient_ff,
   output logic [sdvs_pkg::WORD_W-1:0]      remainder_ff,
   output logic                            even_we_ff,
   output logic                            odd_we_ff,
   // Status word transfer and completion
   output sdvs_pkg::sdvs_cc_s              psw_cc_ff,
   output logic                            psw_load_ff,
   output logic                            done_ff
);
   import sdvs_pkg::*;

   // Sequencer state
   sdvs_state_e        st_ff;                            // Current state
   sdvs_state_e        nxt_st;                           // Next state
   // Datapath registers
   logic [16:0]        partial_remainder_register_ff;    // Signed partial remainder
   logic [16:0]        nxt_prem;                         // Next remainder
   logic [15:0]        quotient_shift_register_ff;       // Low dividend, then quotient
   logic [15:0]        nxt_qsr;                          // Next quotient
   logic [15:0]        dest_ff;                          // Captured divisor
   logic [15:0]        nxt_dest;                         // Next divisor
   logic [3:0]         cnt_ff;                           // Pass counter
   logic [3:0]         nxt_cnt;                          // Next count
   logic               dividend_negative_flag_ff;        // Dividend sign
   logic               nxt_dvd_neg;                      // Next dividend sign
   sdvs_cc_s           local_condition_codes_ff;         // Local codes
   sdvs_cc_s           nxt_lcc;                          // Next local codes
   logic               wr_ok_ff;                         // Results to be written
   logic               nxt_wr_ok;                        // Next write grant
   // Output registers
   logic [15:0]        nxt_quot;                         // Next quotient out
   logic [15:0]        nxt_rem;                          // Next remainder out
   logic               nxt_even_we;                      // Next even write
   logic               nxt_odd_we;                       // Next odd write
   sdvs_cc_s           nxt_psw;                          // Next status codes
   logic               nxt_psw_load;                     // Next status load
   logic               nxt_done;                         // Next done
   // Arithmetic
   logic               divisor_sign_bit;                 // Divisor sign
   logic               low_quotient_bit;                 // Last quotient bit
   logic               remainder_sign_bit;               // Sign of partial remainder
   logic [16:0]        dsr_ext;                          // Sign-extended divisor
   logic [16:0]        shifted;                          // Remainder shifted with top bit
   logic               op_sub;                           // Subtract on this pass
   logic [16:0]        alu_res;                          // Pass result
   logic               alu_top_carry;                    // Quotient bit of this pass
   logic [16:0]        corr_res;                         // Corrected remainder
   logic [15:0]        neg_lo;                           // Negated low word or quotient
   logic [15:0]        neg_hi;                           // Negated high word or remainder
   logic               lo_cy;                            // Carry out of low negation
   logic               hi_cin;                           // Carry into high negation
   logic               signs_differ;                     // Quotient must be negative
   logic [15:0]        quot_val;                         // Signed quotient
   // Check helper
   logic [4:0]         loop_len_ff;                      // Loop cycles in a row
   logic [4:0]         nxt_loop_len;                     // Next loop cycle count

   // Add or subtract choice of one pass
   function automatic logic pick_sub(input logic first,
                                     input logic dsign,
                                     input logic qbit);
      // First pass looks at divisor sign only
      if (first) begin
         pick_sub = ~dsign;
      end else begin
         pick_sub = dsign ^ qbit;
      end
   endfunction

   // Sign and quotient bit taps
   assign divisor_sign_bit   = dest_ff[15];
   assign low_quotient_bit   = quotient_shift_register_ff[0];
   assign remainder_sign_bit = partial_remainder_register_ff[16];
   assign dsr_ext            = {dest_ff[15], dest_ff};

   // One division pass: shift left, add or subtract, quotient bit out
   always_comb begin
      shifted       = {partial_remainder_register_ff[15:0],
                       quotient_shift_register_ff[15]};
      op_sub        = pick_sub(st_ff == S_FIRST, divisor_sign_bit,
                               low_quotient_bit);
      if (op_sub) begin
         alu_res = shifted - dsr_ext;
      end else begin
         alu_res = shifted + dsr_ext;
      end
      alu_top_carry = ~alu_res[16];
   end

   // Correction upward by the divisor magnitude
   always_comb begin
      if (divisor_sign_bit) begin
         corr_res = partial_remainder_register_ff - dsr_ext;
      end else begin
         corr_res = partial_remainder_register_ff + dsr_ext;
      end
   end

   // Low carry feeds high only while negating the dividend
   assign hi_cin = (st_ff == S_NEG) ? lo_cy : 1'b1;

   // Low slice: dividend low word, later the quotient
   sdvs_negate16 u_neg_lo (
      .a    (quotient_shift_register_ff),
      .cin  (1'b1),
      .y    (neg_lo),
      .cout (lo_cy)
   );

   // High slice: dividend high word, later the remainder
   sdvs_negate16 u_neg_hi (
      .a    (partial_remainder_register_ff[15:0]),
      .cin  (hi_cin),
      .y    (neg_hi),
      .cout ()
   );

   // Quotient sign from operand signs
   assign signs_differ = dividend_negative_flag_ff ^ divisor_sign_bit;
   assign quot_val     = signs_differ ? neg_lo : quotient_shift_register_ff;

   // Next-state and datapath decisions
   always_comb begin
      nxt_st       = st_ff;
      nxt_prem     = partial_remainder_register_ff;
      nxt_qsr      = quotient_shift_register_ff;
      nxt_dest     = dest_ff;
      nxt_cnt      = cnt_ff;
      nxt_dvd_neg  = dividend_negative_flag_ff;
      nxt_lcc      = local_condition_codes_ff;
      nxt_wr_ok    = wr_ok_ff;
      nxt_quot     = quotient_ff;
      nxt_rem      = remainder_ff;
      nxt_even_we  = 1'b0;
      nxt_odd_we   = 1'b0;
      nxt_psw      = psw_cc_ff;
      nxt_psw_load = 1'b0;
      nxt_done     = 1'b0;
      case (st_ff)
         // Capture operands on start
         S_IDLE: begin
            if (start) begin
               nxt_prem  = {1'b0, even_source_register};
               nxt_qsr   = odd_companion_register;
               nxt_dest  = destination_operand_register;
               nxt_cnt   = CNT_INIT;
               nxt_wr_ok = 1'b0;
               nxt_st    = S_ZTEST;
            end
         end
         // Zero divisor skips the division
         S_ZTEST: begin
            if (dest_ff == WORD_ZERO) begin
               nxt_lcc = CC_ZERO_DIV;
               nxt_st  = S_DONE;
            end else begin
               nxt_lcc.n   = partial_remainder_register_ff[15];
               nxt_dvd_neg = partial_remainder_register_ff[15];
               nxt_st      = S_NEG;
            end
         end
         // Negative dividend made positive
         S_NEG: begin
            nxt_st = S_FIRST;
            if (dividend_negative_flag_ff) begin
               nxt_prem = {1'b0, neg_hi};
               nxt_qsr  = neg_lo;
               if (neg_hi[15]) begin
                  nxt_lcc.z = 1'b0;
                  nxt_lcc.v = 1'b1;
                  nxt_lcc.c = 1'b0;
                  nxt_st    = S_DONE;
               end
            end
         end
         // First pass, then overflow test
         S_FIRST: begin
            nxt_prem = alu_res;
            nxt_qsr  = {quotient_shift_register_ff[14:0], alu_top_carry};
            nxt_cnt  = cnt_ff - CNT_STEP;
            if (alu_top_carry) begin
               nxt_lcc.z = 1'b0;
               nxt_lcc.v = 1'b1;
               nxt_lcc.c = 1'b0;
               nxt_st    = S_DONE;
            end else begin
               nxt_lcc.c = 1'b0;
               nxt_st    = S_LOOP;
            end
         end
         // Remaining passes until count runs out
         S_LOOP: begin
            nxt_prem = alu_res;
            nxt_qsr  = {quotient_shift_register_ff[14:0], alu_top_carry};
            nxt_cnt  = cnt_ff - CNT_STEP;
            if (cnt_ff == CNT_LAST) begin
               nxt_st = S_CORR;
            end
         end
         // Excess operation undone when last bit is zero
         S_CORR: begin
            if (!low_quotient_bit) begin
               nxt_prem = corr_res;
            end
            nxt_st = S_FIX;
         end
         // Sign fix of both results
         S_FIX: begin
            nxt_st = S_DONE;
            if (signs_differ && (neg_lo == MOST_NEG)) begin
               nxt_lcc.v = 1'b1;
               nxt_lcc.z = 1'b0;
               nxt_lcc.c = 1'b0;
            end else begin
               nxt_quot  = quot_val;
               if (dividend_negative_flag_ff) begin
                  nxt_rem = neg_hi;
               end else begin
                  nxt_rem = partial_remainder_register_ff[15:0];
               end
               nxt_lcc.n = quot_val[15];
               nxt_lcc.z = (quot_val == WORD_ZERO);
               nxt_lcc.v = 1'b0;
               nxt_lcc.c = 1'b0;
               nxt_wr_ok = 1'b1;
            end
         end
         // Results and codes handed over together
         S_DONE: begin
            nxt_even_we  = wr_ok_ff;
            nxt_odd_we   = wr_ok_ff;
            nxt_psw      = local_condition_codes_ff;
            nxt_psw_load = 1'b1;
            nxt_done     = 1'b1;
            nxt_st       = S_IDLE;
         end
         // Unused code returns to idle
         default: begin
            nxt_st = S_IDLE;
         end
      endcase
   end

   // State registers
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         st_ff                         <= S_IDLE;
         partial_remainder_register_ff <= 17'h00000;
         quotient_shift_register_ff    <= WORD_ZERO;
         dest_ff                       <= WORD_ZERO;
         cnt_ff                        <= CNT_LAST;
         dividend_negative_flag_ff     <= 1'b0;
         local_condition_codes_ff      <= CC_RESET;
         wr_ok_ff                      <= 1'b0;
         quotient_ff                   <= WORD_ZERO;
         remainder_ff                  <= WORD_ZERO;
         even_we_ff                    <= 1'b0;
         odd_we_ff                     <= 1'b0;
         psw_cc_ff                     <= CC_RESET;
         psw_load_ff                   <= 1'b0;
         done_ff                       <= 1'b0;
      end else begin
         st_ff                         <= nxt_st;
         partial_remainder_register_ff <= nxt_prem;
         quotient_shift_register_ff    <= nxt_qsr;
         dest_ff                       <= nxt_dest;
         cnt_ff                        <= nxt_cnt;
         dividend_negative_flag_ff     <= nxt_dvd_neg;
         local_condition_codes_ff      <= nxt_lcc;
         wr_ok_ff                      <= nxt_wr_ok;
         quotient_ff                   <= nxt_quot;
         remainder_ff                  <= nxt_rem;
         even_we_ff                    <= nxt_even_we;
         odd_we_ff                     <= nxt_odd_we;
         psw_cc_ff                     <= nxt_psw;
         psw_load_ff                   <= nxt_psw_load;
         done_ff                       <= nxt_done;
      end
   end

   // Checks on the sequence
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (srst);

   // Loop cycles in a row, so the pass check needs no long repetition
   always_comb begin
      nxt_loop_len = (st_ff == S_LOOP) ? (loop_len_ff + 5'h01) : 5'h00;
   end

   // Loop cycle counter register
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         loop_len_ff <= 5'h00;
      end else begin
         loop_len_ff <= nxt_loop_len;
      end
   end

   // Fifteen loop passes follow a clean first pass
   sequence seq_loop_run;
      (st_ff == S_LOOP) ##15 ((st_ff == S_CORR) && (loop_len_ff == {1'b0, CNT_INIT}));
   endsequence

   // Handover two cycles after the final state decision
   sequence seq_handover;
      (st_ff == S_DONE) ##1 done_ff;
   endsequence

   chk_count_load: assert property (st_ff == S_ZTEST |-> cnt_ff == CNT_INIT)
      else $error("pass counter not loaded at entry");

   chk_zero_div: assert property ((st_ff == S_ZTEST) && (dest_ff == WORD_ZERO) |=>
      seq_handover ##0 (!even_we_ff && !odd_we_ff && psw_cc_ff == CC_ZERO_DIV))
      else $error("zero divisor handled wrongly");

   chk_sign_n: assert property ((st_ff == S_ZTEST) && (dest_ff != WORD_ZERO) |=>
      local_condition_codes_ff.n == $past(partial_remainder_register_ff[15]))
      else $error("N does not follow dividend sign");

   chk_most_neg: assert property ((st_ff == S_NEG) && dividend_negative_flag_ff
      && neg_hi[15] |=> (st_ff == S_DONE) && local_condition_codes_ff.v)
      else $error("most negative dividend not aborted");

   chk_pass_count: assert property ((st_ff == S_FIRST) && !alu_top_carry
      |=> seq_loop_run)
      else $error("division loop length wrong");

   chk_ovf_abort: assert property ((st_ff == S_FIRST) && alu_top_carry
      |=> seq_handover ##0 (!even_we_ff && psw_cc_ff.v))
      else $error("quotient overflow not aborted");

   chk_carry_clr: assert property (even_we_ff |-> !psw_cc_ff.c && !psw_cc_ff.v)
      else $error("carry or overflow set on good divide");

   chk_quot_sign: assert property (even_we_ff && (quotient_ff != WORD_ZERO)
      |-> quotient_ff[15] == (dividend_negative_flag_ff ^ dest_ff[15]))
      else $error("quotient sign wrong");

   chk_rem_sign: assert property (odd_we_ff && (remainder_ff != WORD_ZERO)
      |-> remainder_ff[15] == dividend_negative_flag_ff)
      else $error("remainder sign differs from dividend");

   chk_done_pulse: assert property (done_ff |=> !done_ff)
      else $error("done longer than one cycle");

   chk_psw_xfer: assert property (done_ff |-> psw_load_ff
      && (psw_cc_ff == $past(local_condition_codes_ff)))
      else $error("status word transfer wrong");

endmodule

// ### tb/sdvs_host_model.sv
// Host core model: owns the even/odd/destination registers and status copy.
// Assumes the bench asks for one divide at a time through issue.
`timescale 1ns/10ps
module sdvs_host_model (
   // Clock and reset
   input  wire logic                        ref_clk,
   input  wire logic                        srst,
   // Bench request
   input  wire logic                        issue,
   input  wire logic [15:0]                 hi,
   input  wire logic [15:0]                 lo,
   input  wire logic [15:0]                 dv,
   // Request toward the divider
   output logic                             start,
   output logic [sdvs_pkg::WORD_W-1:0]      even_reg,
   output logic [sdvs_pkg::WORD_W-1:0]      odd_reg,
   output logic [sdvs_pkg::WORD_W-1:0]      dest_reg,
   // Answer from the divider
   input  wire logic [sdvs_pkg::WORD_W-1:0] quotient_ff,
   input  wire logic [sdvs_pkg::WORD_W-1:0] remainder_ff,
   input  wire logic                        even_we_ff,
   input  wire logic                        odd_we_ff,
   input  wire sdvs_pkg::sdvs_cc_s          psw_cc_ff,
   input  wire logic                        psw_load_ff,
   input  wire logic                        done_ff,
   // Status word copy and busy flag
   output sdvs_pkg::sdvs_cc_s               psw,
   output logic                             busy
);
   import sdvs_pkg::*;

   // One request in flight; operands never move until done
   always @(posedge ref_clk) begin
      if (srst) begin
         start <= 1'b0;
         busy  <= 1'b0;
         psw   <= CC_RESET;
      end else begin
         start <= 1'b0;
         // Write-back of results and codes
         if (done_ff) begin
            busy <= 1'b0;
            if (even_we_ff) even_reg <= quotient_ff;
            if (odd_we_ff)  odd_reg  <= remainder_ff;
            if (psw_load_ff) psw <= psw_cc_ff;
         end
         // New request: even register holds the high word
         if (!busy && issue && !start) begin
            even_reg <= hi;
            odd_reg  <= lo;
            dest_reg <= dv;
            start    <= 1'b1;
            busy     <= 1'b1;
         end
      end
   end
endmodule

// ### tb/tb_signed_divide_sequencer.sv
// Self-checking bench of the divide sequencer with a host core model.
// Assumes a 40 MHz clock; expectations come from integer arithmetic.
`timescale 1ns/10ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin n_fail++; \
   $display("Error at %0t: got %h expected %h", $time, g, e); end end
module tb_signed_divide_sequencer;
   import sdvs_pkg::*;

   logic               ref_clk = 1'b0; // Bench clock
   logic               srst    = 1'b1; // Sync reset
   logic               issue   = 1'b0; // Request to host model
   logic [15:0]        hi = 16'h0, lo = 16'h0, dv = 16'h0;
   logic               start, even_we_ff, odd_we_ff, psw_load_ff, done_ff, busy;
   logic [WORD_W-1:0]  even_reg, odd_reg, dest_reg, quotient_ff, remainder_ff;
   sdvs_cc_s           psw_cc_ff, psw;
   int                 n_fail = 0, tests_run = 0;
   logic [31:0]        seed = 32'h029A3E3B; // Random state
   logic [47:0]        cases [12] = '{48'h0000_0064_0000, 48'h8000_0000_0003,
      48'h7FFF_FFFF_0001, 48'h0000_0007_0002, 48'hFFFF_FFF9_0002, 48'h0000_0007_FFFE,
      48'hFFFF_FFF9_FFFE, 48'h0000_0000_0005, 48'h0000_0006_0003, 48'hFFFF_8000_0001,
      48'h0000_7FFF_0001, 48'hFFFF_8001_0001};

   // Half period of 12.5 ns
   always #12.5 ref_clk = ~ref_clk;

   sdvs_divider sdvs_divider_i (.ref_clk(ref_clk), .srst(srst), .start(start),
      .even_source_register(even_reg), .odd_companion_register(odd_reg),
      .destination_operand_register(dest_reg), .quotient_ff(quotient_ff),
      .remainder_ff(remainder_ff), .even_we_ff(even_we_ff), .odd_we_ff(odd_we_ff),
      .psw_cc_ff(psw_cc_ff), .psw_load_ff(psw_load_ff), .done_ff(done_ff));

   sdvs_host_model sdvs_host_model_i (.ref_clk(ref_clk), .srst(srst), .issue(issue),
      .hi(hi), .lo(lo), .dv(dv), .start(start), .even_reg(even_reg),
      .odd_reg(odd_reg), .dest_reg(dest_reg), .quotient_ff(quotient_ff),
      .remainder_ff(remainder_ff), .even_we_ff(even_we_ff), .odd_we_ff(odd_we_ff),
      .psw_cc_ff(psw_cc_ff), .psw_load_ff(psw_load_ff), .done_ff(done_ff),
      .psw(psw), .busy(busy));

   // Xorshift source
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   // Counts and verdict
   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // One divide through the host, checked against integer model
   task automatic run(input logic [15:0] h, input logic [15:0] l, input logic [15:0] d);
      longint a, b, q, r, m;
      int lat, k;
      logic [3:0] cc;
      logic [15:0] eq, er;
      logic wr;
      a = longint'($signed({h, l}));
      b = longint'($signed(d));
      eq = h;
      er = l;
      wr = 1'b0;
      // Zero divisor, most negative dividend, overflow, normal
      if (b == 0) begin
         lat = 3;
         cc = 4'h7;
      end else if (a == -64'sd2147483648) begin
         lat = 4;
         cc = 4'hA;
      end else begin
         m = (a < 0 ? -a : a) / (b < 0 ? -b : b);
         if (m >= 32768) begin
            lat = 5;
            cc = {a < 0, 3'b010};
         end else begin
            q = a / b;
            r = a % b;
            eq = q[15:0];
            er = r[15:0];
            wr = 1'b1;
            lat = 22;
            cc = {eq[15], eq == 16'h0, 2'b00};
         end
      end
      hi = h;
      lo = l;
      dv = d;
      issue = 1'b1;
      k = 0;
      do begin
         @(posedge ref_clk);
         #1;
         issue = 1'b0;
         k++;
      end while (done_ff !== 1'b1 && k < 40);
      `CHK(k, lat + 1)
      `CHK(even_we_ff, wr)
      `CHK(odd_we_ff, wr)
      `CHK(psw_load_ff, 1'b1)
      @(posedge ref_clk);
      #1;
      `CHK(done_ff, 1'b0)
      `CHK(even_reg, eq)
      `CHK(odd_reg, er)
      `CHK(psw, cc)
      `CHK(busy, 1'b0)
      $display("case %h%h / %h took %0d cycles", h, l, d, k);
   endtask

   // Watchdog
   initial begin
      #200000;
      n_fail++;
      wrap_up();
   end

   // Main sequence
   initial begin
      logic [31:0] r, d;
      repeat (20) @(posedge ref_clk);
      #1;
      srst = 1'b0;
      `CHK(psw_cc_ff, CC_RESET)
      `CHK(done_ff, 1'b0)
      foreach (cases[i]) run(cases[i][47:32], cases[i][31:16], cases[i][15:0]);
      for (int i = 0; i < 24; i++) begin
         r = xs();
         d = xs();
         run(r[31] ? {16{r[15]}} : 16'(r[30:16] >> d[19:16]), r[15:0], d[15:0]);
      end
      // Reset in mid-divide, then recovery
      hi = 16'h0;
      lo = 16'h0064;
      dv = 16'h0007;
      issue = 1'b1;
      repeat (6) @(posedge ref_clk);
      #1;
      issue = 1'b0;
      srst = 1'b1;
      repeat (2) @(posedge ref_clk);
      #1;
      srst = 1'b0;
      `CHK(psw_cc_ff, CC_RESET)
      run(16'h0000, 16'h0064, 16'hFFF9);
      wrap_up();
   end
endmodule
